// *** hdl/afe_regs_pkg.sv ***
// package: register map, field layout and reset values of the front end register bank
package afe_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int WORD_W = 10;
  localparam int LINE_W = 14;
  // offsets
  localparam logic [7:0] SYNC_SEL_ADDR = 8'h11;
  localparam logic [7:0] RED_GAIN_HIGH_ADDR = 8'h12;
  localparam logic [7:0] RED_GAIN_LOW_ADDR = 8'h13;
  localparam logic [7:0] GREEN_GAIN_HIGH_ADDR = 8'h14;
  localparam logic [7:0] GREEN_GAIN_LOW_ADDR = 8'h15;
  localparam logic [7:0] BLUE_GAIN_HIGH_ADDR = 8'h16;
  localparam logic [7:0] BLUE_GAIN_LOW_ADDR = 8'h17;
  localparam logic [7:0] RED_OFFSET_HIGH_ADDR = 8'h18;
  localparam logic [7:0] RED_OFFSET_LOW_ADDR = 8'h19;
  localparam logic [7:0] GREEN_OFFSET_HIGH_ADDR = 8'h1a;
  localparam logic [7:0] GREEN_OFFSET_LOW_ADDR = 8'h1b;
  localparam logic [7:0] BLUE_OFFSET_HIGH_ADDR = 8'h1c;
  localparam logic [7:0] BLUE_OFFSET_LOW_ADDR = 8'h1d;
  localparam logic [7:0] LINE_LENGTH_HIGH_ADDR = 8'h1e;
  localparam logic [7:0] LINE_LENGTH_LOW_ADDR = 8'h1f;
  localparam logic [7:0] SYNC_STATUS_ADDR = 8'h30;
  localparam logic [7:0] BLACK_LOOP_ADDR = 8'h27;
  // reset values
  localparam logic [7:0] GAIN_HIGH_RST = 8'h55;
  localparam logic [7:0] OFFSET_HIGH_RST = 8'h80;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] LINE_HIGH_RST = 8'h06;
  localparam logic [7:0] LINE_LOW_RST = 8'h98;
  localparam logic [7:0] SYNC_SEL_RST = 8'h00;
  localparam logic [7:0] BLACK_LOOP_RST = 8'h40;
  // field layout
  localparam int SYNC_MODE_BIT = 0;
  localparam int HSRC_BIT = 1;
  localparam int VSRC_BIT = 2;
  localparam int LOOP_OFF_BIT = 7;
  localparam logic [7:0] LOW_FIELD_MASK = 8'hc0;
  localparam int LOW_FIELD_LSB = 6;
  localparam logic [7:0] LINE_HIGH_MASK = 8'h3f;
  localparam logic [7:0] SYNC_SEL_MASK = 8'h07;
  localparam logic [9:0] OFFSET_MID = 10'h200;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int NCH = 3;

  // per-channel settings toward the converters and the offset adder
  typedef struct packed {
    logic [WORD_W-1:0] gain;
    logic [WORD_W-1:0] offset_dac;
    logic signed [WORD_W-1:0] digital_offset;
  } chan_ctrl_s;

  // chosen sync routing
  typedef struct packed {
    logic hsync_from_sog;
    logic vsync_from_separator;
  } sync_route_s;
endpackage : afe_regs_pkg

// *** hdl/afe_gain_offset_sync_regs.sv ***
// module: gain, offset, line length and sync source register bank
`timescale 1ns/10ps
// Contract
// R1 - bit 0 low: sync sources chosen automatically, reported
// R2 - bit 0 high: bits 1 and 2 choose
// R3 - horizontal bit: 0 sync pin, 1 sync_on_green
// R4 - vertical bit: 0 sync pin, 1 separator
// R5 - gain is 0.5 plus word over 682
// R6 - gain word: high byte, low bits 7:6
// R7 - gain 0x55/00 unity, 0xff/c0 maximum
// R8 - loop off: offset high byte drives converter
// R9 - loop on: offset high byte signed, 0x80 zero
// R10 - offset word low bits from 7:6
// R11 - 14-bit line length applied on low write
// R12 - software writes line high before low
// R13 - loop disable bypasses adder, same latency
// R14 - unused low bits read zero, ignore writes
module afe_gain_offset_sync_regs
  import afe_regs_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  // sync activity seen on the pins, asynchronous
  input wire logic hsync_active_in,
  input wire logic sog_active_in,
  input wire logic vsync_active_in,
  // sync routing toward the muxes
  output sync_route_s route_out,
  // per-channel settings: 0 red, 1 green, 2 blue
  output chan_ctrl_s [NCH-1:0] chan_out,
  output logic black_loop_off_out,
  // line length toward the pixel-clock loop
  output logic [LINE_W-1:0] line_length_out,
  output logic line_length_load_out
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] gain_high [NCH];
  logic [DATA_W-1:0] gain_low [NCH];
  logic [DATA_W-1:0] offset_high [NCH];
  logic [DATA_W-1:0] offset_low [NCH];
  logic [DATA_W-1:0] line_length_high;
  logic [DATA_W-1:0] line_length_low;
  logic [DATA_W-1:0] sync_source_select;
  logic [DATA_W-1:0] black_loop_cfg;
  logic [2:0] hs_sync;
  logic [2:0] sog_sync;
  logic [2:0] vs_sync;
  logic hs_seen;
  logic sog_seen;
  logic vs_seen;
  sync_route_s auto_route;
  logic [DATA_W-1:0] next_rdata;

  // decoded address of a channel byte: base plus 2 per channel
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                               input int ch);
    hit = (a == base + ADDR_W'(2 * ch));
  endfunction : hit

  // ----------------------------------------------------------------
  // channel registers
  // ----------------------------------------------------------------
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_chan
      // gain and offset bytes, low bytes keep only bits 7:6
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          gain_high[c] <= GAIN_HIGH_RST; // R7
          gain_low[c] <= LOW_RST;
          offset_high[c] <= OFFSET_HIGH_RST;
          offset_low[c] <= LOW_RST;
        end else if (ce_in && wr_in) begin
          if (hit(addr_in, RED_GAIN_HIGH_ADDR, c)) begin
            gain_high[c] <= wdata_in;
          end
          if (hit(addr_in, RED_GAIN_LOW_ADDR, c)) begin
            gain_low[c] <= wdata_in & LOW_FIELD_MASK; // R14
          end
          if (hit(addr_in, RED_OFFSET_HIGH_ADDR, c)) begin
            offset_high[c] <= wdata_in;
          end
          if (hit(addr_in, RED_OFFSET_LOW_ADDR, c)) begin
            offset_low[c] <= wdata_in & LOW_FIELD_MASK; // R14
          end
        end
      end

      // 10-bit words; converters get the offset word, adder the signed one
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          chan_out[c].gain <= {GAIN_HIGH_RST, 2'b00};
          chan_out[c].offset_dac <= OFFSET_MID;
          chan_out[c].digital_offset <= '0;
        end else if (ce_in) begin
          // R5 R6 R7
          chan_out[c].gain <= {gain_high[c], gain_low[c][LOW_FIELD_LSB +: 2]};
          // R8 R10
          chan_out[c].offset_dac <= {offset_high[c], offset_low[c][LOW_FIELD_LSB +: 2]};
          // adder input zero while loop is off, register stage kept either way
          if (black_loop_cfg[LOOP_OFF_BIT]) begin
            chan_out[c].digital_offset <= '0; // R13
          end else begin
            chan_out[c].digital_offset <= // R9
              {offset_high[c], offset_low[c][LOW_FIELD_LSB +: 2]} - OFFSET_MID;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // line length, sync select, loop configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      line_length_high <= LINE_HIGH_RST;
      line_length_low <= LINE_LOW_RST;
      sync_source_select <= SYNC_SEL_RST;
      black_loop_cfg <= BLACK_LOOP_RST;
    end else if (ce_in && wr_in) begin
      unique case (addr_in)
        LINE_LENGTH_HIGH_ADDR: line_length_high <= wdata_in & LINE_HIGH_MASK;
        LINE_LENGTH_LOW_ADDR: line_length_low <= wdata_in;
        SYNC_SEL_ADDR: sync_source_select <= wdata_in & SYNC_SEL_MASK;
        BLACK_LOOP_ADDR: black_loop_cfg <= wdata_in;
        default: ;
      endcase
    end
  end

  // loop sees a new length only after the low byte is written
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      line_length_out <= {LINE_HIGH_RST[5:0], LINE_LOW_RST};
      line_length_load_out <= 1'b0;
    end else if (ce_in) begin
      line_length_load_out <= wr_in && (addr_in == LINE_LENGTH_LOW_ADDR); // R11 R12
      if (wr_in && (addr_in == LINE_LENGTH_LOW_ADDR)) begin
        line_length_out <= {line_length_high[5:0], wdata_in}; // R11
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      black_loop_off_out <= 1'b0;
    end else if (ce_in) begin
      black_loop_off_out <= black_loop_cfg[LOOP_OFF_BIT]; // R13
    end
  end

  // ----------------------------------------------------------------
  // sync activity synchronisers and routing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hs_sync <= '0;
      sog_sync <= '0;
      vs_sync <= '0;
      hs_seen <= 1'b0;
      sog_seen <= 1'b0;
      vs_seen <= 1'b0;
    end else if (ce_in) begin
      hs_sync <= {hs_sync[1:0], hsync_active_in};
      sog_sync <= {sog_sync[1:0], sog_active_in};
      vs_sync <= {vs_sync[1:0], vsync_active_in};
      // a change counts once the second and third stages agree
      if (hs_sync[1] == hs_sync[2]) begin
        hs_seen <= hs_sync[2];
      end
      if (sog_sync[1] == sog_sync[2]) begin
        sog_seen <= sog_sync[2];
      end
      if (vs_sync[1] == vs_sync[2]) begin
        vs_seen <= vs_sync[2];
      end
    end
  end

  // automatic choice: dedicated pins preferred while active
  always_comb begin
    auto_route.hsync_from_sog = !hs_seen && sog_seen; // R1
    auto_route.vsync_from_separator = !vs_seen; // R1
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      route_out <= '0;
    end else if (ce_in) begin
      if (sync_source_select[SYNC_MODE_BIT]) begin
        route_out.hsync_from_sog <= sync_source_select[HSRC_BIT]; // R2 R3
        route_out.vsync_from_separator <= sync_source_select[VSRC_BIT]; // R2 R4
      end else begin
        route_out <= auto_route; // R1
      end
    end
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = ZERO_BYTE;
    for (int c = 0; c < NCH; c++) begin
      if (hit(addr_in, RED_GAIN_HIGH_ADDR, c)) next_rdata = gain_high[c];
      if (hit(addr_in, RED_GAIN_LOW_ADDR, c)) next_rdata = gain_low[c]; // R14
      if (hit(addr_in, RED_OFFSET_HIGH_ADDR, c)) next_rdata = offset_high[c];
      if (hit(addr_in, RED_OFFSET_LOW_ADDR, c)) next_rdata = offset_low[c]; // R14
    end
    unique case (addr_in)
      LINE_LENGTH_HIGH_ADDR: next_rdata = line_length_high;
      LINE_LENGTH_LOW_ADDR: next_rdata = line_length_low;
      SYNC_SEL_ADDR: next_rdata = sync_source_select;
      BLACK_LOOP_ADDR: next_rdata = black_loop_cfg;
      // chosen multiplexer settings, whatever the mode
      SYNC_STATUS_ADDR: next_rdata = {6'b00_0000, route_out.vsync_from_separator,
                                      route_out.hsync_from_sog}; // R1
      default: ;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= ZERO_BYTE;
    end else if (ce_in) begin
      rdata_out <= rd_in ? next_rdata : ZERO_BYTE;
    end
  end

endmodule : afe_gain_offset_sync_regs

// *** bench/afe_regs_assertions.sv ***
// checker: port-level assertions for the gain, offset, line length and sync register bank
`timescale 1ns/10ps
module afe_regs_assertions
  import afe_regs_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [DATA_W-1:0] rdata_out,
  // settings outputs
  input wire sync_route_s route_out,
  input wire chan_ctrl_s [NCH-1:0] chan_out,
  input wire logic black_loop_off_out,
  input wire logic [LINE_W-1:0] line_length_out,
  input wire logic line_length_load_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // taken strobes and data slices
  wire wr_ok = ce_in && wr_in;
  wire ll_wr = wr_ok && addr_in == LINE_LENGTH_LOW_ADDR;
  wire msb = wdata_in[LOOP_OFF_BIT];
  wire [1:0] hv_sel = {wdata_in[HSRC_BIT], wdata_in[VSRC_BIT]};

  a_low_zero: assert property (ce_in && rd_in && addr_in inside {[8'h13:8'h1d]}
    && addr_in[0] |=> rdata_out[5:0] == 6'h00) else $error("low byte spare bits not zero");
  a_line_load: assert property (ll_wr |=> line_length_load_out
    && line_length_out[7:0] == $past(wdata_in)) else $error("line length not loaded");
  a_load_cause: assert property (line_length_load_out && $past(ce_in) |-> $past(ll_wr))
    else $error("load pulse without low write");
  a_line_hold: assert property (!line_length_load_out |-> $stable(line_length_out))
    else $error("line length moved without load");
  a_gain_high: assert property (wr_ok && addr_in == RED_GAIN_HIGH_ADDR ##1 ce_in
    |=> chan_out[0].gain[9:2] == $past(wdata_in, 2)) else $error("gain high bits wrong");
  a_manual_route: assert property (wr_ok && addr_in == SYNC_SEL_ADDR && wdata_in[0]
    ##1 ce_in |=> route_out == $past(hv_sel, 2)) else $error("manual routing wrong");
  a_loop_bit: assert property (wr_ok && addr_in == BLACK_LOOP_ADDR ##1 ce_in
    |=> black_loop_off_out == $past(msb, 2)) else $error("loop disable wrong");
  a_adder_bypass: assert property (black_loop_off_out
    |-> chan_out[2].digital_offset == 10'h000) else $error("adder not bypassed");

  // main scenarios reached
  c_line: cover property (ll_wr);
  c_loop_off: cover property (black_loop_off_out);
  c_manual: cover property (wr_ok && addr_in == SYNC_SEL_ADDR && wdata_in[0]);
endmodule : afe_regs_assertions

// *** bench/afe_gain_offset_sync_regs_test.sv ***
// testbench: register bank reads, writes and settings outputs
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module afe_gain_offset_sync_regs_test
  import afe_regs_pkg::*;
;
  logic clk_in = 0, srst_in = 1, ce_in = 1, wr_in = 0, rd_in = 0, rd_d = 0;
  logic hs = 1, sg = 0, vs = 1, off, loop_off, ld;
  logic [7:0] addr_in = 0, wdata_in = 0, rdata_out;
  logic [7:0] sh [0:255];
  logic [7:0] pat [2] = '{8'h00, 8'hff};
  logic [13:0] len;
  logic [9:0] w;
  logic [2:0] j;
  logic [1:0] e;
  sync_route_s route_out;
  chan_ctrl_s [NCH-1:0] chan_out;
  logic [7:0] rq[$];
  logic [13:0] lq[$];
  logic [7:0] exp_rd;
  logic [13:0] exp_len;
  int bad_count = 0, checks_done = 0;

  always #10 clk_in = ~clk_in;
  afe_gain_offset_sync_regs u_dut (
    .clk_in, .srst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .hsync_active_in(hs), .sog_active_in(sg), .vsync_active_in(vs), .route_out,
    .chan_out, .black_loop_off_out(loop_off), .line_length_out(len),
    .line_length_load_out(ld));

  // result watcher: oldest note against what appears
  always @(posedge clk_in) rd_d <= rd_in && ce_in;
  // each note is taken off once, so a mismatch cannot pop a second note
  always @(negedge clk_in) begin
    if (rd_d) begin
      exp_rd = rq.pop_front();
      `CHK("rdata", exp_rd, rdata_out)
    end
    if (ld) begin
      exp_len = lq.pop_front();
      `CHK("length", exp_len, len)
    end
  end

  // implemented bits of each place
  function automatic logic [7:0] m(input logic [7:0] a);
    if (a == 8'h11) return 8'h07;
    if (a == 8'h1e) return 8'h3f;
    if (a == 8'h27) return 8'hff;
    if (a < 8'h12 || a > 8'h1f) return 8'h00;
    return (a[0] && a != 8'h1f) ? 8'hc0 : 8'hff;
  endfunction : m

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    if (a == 8'h1f) lq.push_back({sh[8'h1e][5:0], v});
    sh[a] = v & m(a);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    rq.push_back(sh[a]);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : rd

  // channel words against the shadow
  task automatic chk_ch;
    `CHK("off", off, loop_off)
    for (int c = 0; c < 3; c++) begin
      `CHK("gain", {sh[8'h12 + 2 * c], sh[8'h13 + 2 * c][7:6]}, chan_out[c].gain)
      w = {sh[8'h18 + 2 * c], sh[8'h19 + 2 * c][7:6]};
      `CHK("dac", w, chan_out[c].offset_dac)
      if (off) `CHK("dig", 10'h000, chan_out[c].digital_offset)
      else `CHK("dig", w - 10'h200, chan_out[c].digital_offset)
    end
  endtask : chk_ch

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // watchdog
  initial begin
    repeat (4000) @(posedge clk_in);
    bad_count++;
    stop_test;
  end

  initial begin
    for (int a = 0; a < 256; a++) sh[a] = 8'h00;
    for (int a = 8'h12; a < 8'h1e; a += 2) sh[a] = (a < 8'h18) ? 8'h55 : 8'h80;
    sh[8'h1e] = 8'h06;
    sh[8'h1f] = 8'h98;
    sh[8'h27] = 8'h40;
    off = 0;
    void'($urandom(6));
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    // reset values over the map, unmapped places included
    for (int a = 8'h11; a < 8'h28; a++) rd(8'(a));
    rd(8'h40);
    #1 `CHK("len", 14'h0698, len)
    `CHK("route", 2'b00, route_out)
    chk_ch;
    $display("reset test done");
    // random contents, line high before line low
    for (int a = 8'h11; a < 8'h20; a++) wr(8'(a), 8'($urandom));
    wr(8'h40, 8'($urandom));
    for (int a = 8'h11; a < 8'h20; a++) rd(8'(a));
    rd(8'h40);
    #1 chk_ch;
    $display("random test done");
    // gain end points, line length extremes, both loop modes
    foreach (pat[k]) begin
      wr(8'h12, pat[k]);
      wr(8'h13, pat[k]);
      wr(8'h1e, pat[k]);
      wr(8'h1f, pat[k]);
      wr(8'h27, {~pat[k][0], 7'h40});
      off = ~pat[k][0];
      rd(8'h13);
      rd(8'h27);
      #1 chk_ch;
    end
    $display("limits test done");
    // manual routing codes, then automatic choice from activity
    for (int i = 0; i < 12; i++) begin
      j = 3'(i);
      if (i < 4) begin
        wr(8'h11, {5'h00, j[1:0], 1'b1});
        e = {j[0], j[1]};
      end else begin
        {vs, sg, hs} <= j;
        wr(8'h11, 8'h00);
        e = {~j[0] & j[1], ~j[2]};
      end
      repeat (6) @(posedge clk_in);
      #1 `CHK("route", e, route_out)
      sh[8'h30] = {6'h00, e[0], e[1]};
      rd(8'h30);
    end
    // clock enable low: the write is not taken
    @(posedge clk_in);
    ce_in <= 1'b0;
    addr_in <= 8'h14;
    wdata_in <= ~sh[8'h14];
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    ce_in <= 1'b1;
    rd(8'h14);
    repeat (2) @(posedge clk_in);
    `CHK("queues", 0, rq.size() + lq.size())
    $display("sync test done");
    stop_test;
  end
endmodule : afe_gain_offset_sync_regs_test

bind afe_gain_offset_sync_regs afe_regs_assertions u_chk (.*);
